/* File: shared/timer_ctl_params.svh */
// Constants of the dual-half timer mode and control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TIMER_CTL_PARAMS_SVH
`define TIMER_CTL_PARAMS_SVH
`define ADDR_GLOBAL_CONFIG 12'h000
`define ADDR_HALF_A_MODE 12'h004
`define ADDR_HALF_B_MODE 12'h008
`define ADDR_TIMER_CONTROL 12'h00c
`define CFG_MSB 2
`define MODE_MSB 3
`define MODE_FIELD_MSB 1
`define CTL_EVENT_MSB 11
`define CTL_EVENT_LSB 10
`define CTL_FREEZE_BIT 9
`define CTL_ENABLE_BIT 8
`define CTL_INVERT_BIT 6
`define CTL_TRIGGER_BIT 5
`define CFG_COMBINED 3'h0
`define CFG_CLOCK 3'h1
`define CFG_SPLIT_BIT 2
`define MODE_RESERVED 2'h0
`define MODE_ONE_SHOT 2'h1
`define MODE_PERIODIC 2'h2
`define MODE_CAPTURE 2'h3
`define EDGE_RISING 2'h0
`define EDGE_FALLING 2'h1
`define EDGE_BOTH 2'h3
`define RESET_CFG 3'h0
`define RESET_MODE 4'h0
`define RESET_FIELD 1'b0
`define RESET_EDGE 2'h0
`endif

/* File: shared/timer_ctl_pkg.sv */
// Types of the dual-half timer mode and control block.
// Assumes the constants header sits beside it.
`include "timer_ctl_params.svh"
package timer_ctl_pkg;
  typedef enum logic [4:0] {
    OP_OFF = 5'h01,
    OP_ONE_SHOT = 5'h02,
    OP_PERIODIC = 5'h04,
    OP_CAPTURE = 5'h08,
    OP_CLOCK = 5'h10
  } op_mode_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic [2:0] global_config;
    logic [3:0] half_a_mode;
    logic [3:0] half_b_mode;
    logic [1:0] edge_select;
    logic debug_freeze;
    logic run_enable;
    logic pwm_invert;
    logic trigger_enable;
    logic [31:0] rdata;
    logic slverr;
  } ctl_state_s;

  typedef struct packed {
    op_mode_e a_mode;
    op_mode_e b_mode;
    logic split;
    logic b_run;
    logic b_capture_armed;
    logic b_rise;
    logic b_fall;
  } half_ctl_s;
endpackage : timer_ctl_pkg

/* File: verilog/timer_mode_control.sv */
// Mode, enable, edge, freeze, PWM inversion and converter trigger control of a dual-half timer.
// Assumes an APB master on pclk; the counting datapath uses the decoded controls.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_params.svh"
module timer_mode_control (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire timer_ctl_pkg::apb_req_s apb_req,
  output timer_ctl_pkg::apb_rsp_s apb_rsp,
  // Debug and datapath.
  input wire logic debug_halted,
  input wire logic half_a_pwm_raw,
  input wire logic half_a_trigger_raw,
  output timer_ctl_pkg::half_ctl_s half_ctl,
  output logic half_a_pwm_out,
  output logic half_a_converter_trigger,
  output logic half_b_count_enable
);
  import timer_ctl_pkg::*;

  ctl_state_s state_q;
  ctl_state_s state_d;

  function automatic op_mode_e decode_mode(input logic [1:0] field, input logic en);
    op_mode_e m;
    m = OP_OFF;
    if (en) begin
      unique case (field)
        `MODE_ONE_SHOT: m = OP_ONE_SHOT;
        `MODE_PERIODIC: m = OP_PERIODIC;
        `MODE_CAPTURE: m = OP_CAPTURE;
        default: m = OP_OFF;
      endcase
    end
    return m;
  endfunction : decode_mode

  function automatic logic [31:0] control_word(input ctl_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CTL_EVENT_MSB:`CTL_EVENT_LSB] = s.edge_select;
    w[`CTL_FREEZE_BIT] = s.debug_freeze;
    w[`CTL_ENABLE_BIT] = s.run_enable;
    w[`CTL_INVERT_BIT] = s.pwm_invert;
    w[`CTL_TRIGGER_BIT] = s.trigger_enable;
    return w;
  endfunction : control_word

  logic access;
  logic split;
  logic combined;
  logic rtc_cfg;
  logic [1:0] b_field;

  assign access = apb_req.psel && apb_req.penable;

  always_comb begin
    state_d = state_q;
    if (access && apb_req.pwrite) begin
      state_d.slverr = 1'b0;
      unique case (apb_req.paddr)
        `ADDR_GLOBAL_CONFIG: state_d.global_config = apb_req.pwdata[`CFG_MSB:0];
        `ADDR_HALF_A_MODE: state_d.half_a_mode = apb_req.pwdata[`MODE_MSB:0];
        `ADDR_HALF_B_MODE: state_d.half_b_mode = apb_req.pwdata[`MODE_MSB:0];
        `ADDR_TIMER_CONTROL: begin
          state_d.edge_select = apb_req.pwdata[`CTL_EVENT_MSB:`CTL_EVENT_LSB];
          state_d.debug_freeze = apb_req.pwdata[`CTL_FREEZE_BIT];
          state_d.run_enable = apb_req.pwdata[`CTL_ENABLE_BIT];
          state_d.pwm_invert = apb_req.pwdata[`CTL_INVERT_BIT];
          state_d.trigger_enable = apb_req.pwdata[`CTL_TRIGGER_BIT];
        end
        default: state_d.slverr = 1'b1;
      endcase
    end else if (access) begin
      state_d.slverr = 1'b0;
      state_d.rdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        `ADDR_GLOBAL_CONFIG: state_d.rdata[`CFG_MSB:0] = state_q.global_config;
        `ADDR_HALF_A_MODE: state_d.rdata[`MODE_MSB:0] = state_q.half_a_mode;
        `ADDR_HALF_B_MODE: state_d.rdata[`MODE_MSB:0] = state_q.half_b_mode;
        `ADDR_TIMER_CONTROL: state_d.rdata = control_word(state_q);
        default: state_d.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.global_config <= `RESET_CFG;
      state_q.half_a_mode <= `RESET_MODE;
      state_q.half_b_mode <= `RESET_MODE;
      state_q.edge_select <= `RESET_EDGE;
      state_q.debug_freeze <= `RESET_FIELD;
      state_q.run_enable <= `RESET_FIELD;
      state_q.pwm_invert <= `RESET_FIELD;
      state_q.trigger_enable <= `RESET_FIELD;
      state_q.rdata <= 32'h0000_0000;
      state_q.slverr <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Read data and error are registered at the access edge, so each access takes one wait cycle.
  logic ack_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access && !ack_q;
    end
  end

  always_comb begin
    apb_rsp.pready = ack_q;
    apb_rsp.pslverr = ack_q && state_q.slverr;
    apb_rsp.prdata = state_q.rdata;
  end

  // Configuration decode for both halves.
  assign split = state_q.global_config[`CFG_SPLIT_BIT];
  assign combined = state_q.global_config == `CFG_COMBINED;
  assign rtc_cfg = state_q.global_config == `CFG_CLOCK;
  // Outside the split configuration b_field takes the half A mode field, but b_mode is OP_OFF and b_capture_armed is low there.
  assign b_field = split ? state_q.half_b_mode[`MODE_FIELD_MSB:0]
                         : state_q.half_a_mode[`MODE_FIELD_MSB:0];

  // Freeze matters only while the debugger holds the core halted.
  assign half_b_count_enable = state_q.run_enable
                               && !(state_q.debug_freeze && debug_halted);

  always_comb begin
    half_ctl.split = split;
    half_ctl.a_mode = rtc_cfg ? OP_CLOCK
                    : decode_mode(state_q.half_a_mode[`MODE_FIELD_MSB:0], combined || split);
    half_ctl.b_mode = split ? decode_mode(b_field, 1'b1) : OP_OFF;
    half_ctl.b_run = half_b_count_enable && split;
    half_ctl.b_capture_armed = state_q.run_enable && split
                               && (b_field == `MODE_CAPTURE);
    half_ctl.b_rise = state_q.edge_select == `EDGE_RISING
                      || state_q.edge_select == `EDGE_BOTH;
    half_ctl.b_fall = state_q.edge_select == `EDGE_FALLING
                      || state_q.edge_select == `EDGE_BOTH;
  end

  assign half_a_pwm_out = half_a_pwm_raw ^ state_q.pwm_invert;
  assign half_a_converter_trigger = half_a_trigger_raw && state_q.trigger_enable;
endmodule : timer_mode_control
`default_nettype wire

/* File: tb/timer_ctl_monitor.sv */
// Port checker of the timer control block.
// Assumes it is bound onto timer_mode_control.
`timescale 1ns/1ps
`default_nettype none
module timer_ctl_monitor (
  // Watched ports.
  input wire logic pclk,
  input wire logic presetn,
  input wire timer_ctl_pkg::apb_req_s apb_req,
  input wire logic debug_halted,
  input wire logic half_a_pwm_raw,
  input wire logic half_a_trigger_raw,
  input wire timer_ctl_pkg::half_ctl_s half_ctl,
  input wire logic half_a_pwm_out,
  input wire logic half_a_converter_trigger,
  input wire logic half_b_count_enable
);
  import timer_ctl_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_b_mode_combined: assert property (!half_ctl.split |-> half_ctl.b_mode == OP_OFF)
    else $error("half B mode not off");
  chk_clock_not_split: assert property (half_ctl.a_mode == OP_CLOCK |-> !half_ctl.split)
    else $error("clock mode while split");
  chk_b_mode_legal: assert property (half_ctl.b_mode != OP_CLOCK)
    else $error("half B in clock mode");
  chk_trigger_gate: assert property (half_a_converter_trigger |-> half_a_trigger_raw)
    else $error("trigger without source");
  chk_pwm_follow_raw: assert property ($changed(half_a_pwm_raw) && !$past(apb_req.penable)
    |-> $changed(half_a_pwm_out)) else $error("pwm output did not follow");
  chk_enable_cause: assert property ($changed(half_b_count_enable)
    |-> $changed(debug_halted) || $past(apb_req.penable)) else $error("enable moved");
  chk_freeze_no_rise: assert property ($rose(debug_halted) && !$past(apb_req.penable)
    |-> !$rose(half_b_count_enable)) else $error("halt raised enable");
  chk_mode_cause: assert property ($changed(half_ctl) |-> $past(apb_req.penable))
    else $error("mode moved without write");
endmodule : timer_ctl_monitor
bind timer_mode_control timer_ctl_monitor mon (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .debug_halted(debug_halted), .half_a_pwm_raw(half_a_pwm_raw),
  .half_a_trigger_raw(half_a_trigger_raw), .half_ctl(half_ctl),
  .half_a_pwm_out(half_a_pwm_out), .half_a_converter_trigger(half_a_converter_trigger),
  .half_b_count_enable(half_b_count_enable));
`default_nettype wire

/* File: tb/timer_mode_control_fields_bench.sv */
// Self-checking bench of the timer control block.
// Assumes design and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module timer_mode_control_fields_bench;
  import timer_ctl_pkg::*;
  logic pclk, presetn, halt, pwm, trg, pwm_o, trg_o, ben, er;
  apb_req_s req;
  apb_rsp_s rsp;
  half_ctl_s hc;
  logic [31:0] rd;
  int fail_count, compares, cyc;
  timer_mode_control uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .debug_halted(halt), .half_a_pwm_raw(pwm), .half_a_trigger_raw(trg), .half_ctl(hc),
    .half_a_pwm_out(pwm_o), .half_a_converter_trigger(trg_o), .half_b_count_enable(ben));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task test_done;
    $display("Compares %0d errors %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // Sample the answer while it stands, half a cycle before the edge that completes it.
    do begin
      @(negedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 9);
    rd = rsp.prdata;
    er = rsp.pslverr;
    if (rsp.pready !== 1'b1) begin
      fail_count++;
      $display("Error pready expected 1 seen %b", rsp.pready);
    end
    @(posedge pclk);
    req <= '0;
    @(posedge pclk);
    #1;
  endtask : bus
  task drv(input logic h, input logic p, input logic t);
    @(posedge pclk);
    halt <= h;
    pwm <= p;
    trg <= t;
    #1;
  endtask : drv
  task t_reset;
    drv(1'b1, 1'b1, 1'b1);
    chk("pwm", 1, pwm_o);
    chk("trigger", 0, trg_o);
    chk("enable", 0, ben);
    bus(1'b0, 12'h00c, 32'h0);
    chk("control", 0, rd);
  endtask : t_reset
  task t_ctl;
    bus(1'b1, 12'h00c, 32'hffffffff);
    bus(1'b0, 12'h00c, 32'h0);
    chk("control", 32'h00000f60, rd);
    chk("pwm", 0, pwm_o);
    chk("trigger", 1, trg_o);
    chk("enable", 0, ben);
    drv(1'b0, 1'b0, 1'b0);
    chk("enable", 1, ben);
    chk("pwm", 1, pwm_o);
    bus(1'b1, 12'h00c, 32'h100);
    drv(1'b1, 1'b0, 1'b0);
    chk("enable", 1, ben);
    bus(1'b1, 12'h00c, 32'h0);
    chk("enable", 0, ben);
    bus(1'b1, 12'h010, 32'hffffffff);
    chk("slverr", 1, er);
  endtask : t_ctl
  task t_modes;
    for (int c = 4; c < 8; c++) begin
      bus(1'b1, 12'h000, 32'(c));
      chk("split", 1, hc.split);
    end
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, 12'h008, 32'(m));
      chk("b_mode", 32'h1 << m, hc.b_mode);
    end
    bus(1'b1, 12'h004, 32'h2);
    bus(1'b1, 12'h000, 32'h0);
    chk("b_mode", 32'h01, hc.b_mode);
    chk("a_mode", 32'h04, hc.a_mode);
    bus(1'b1, 12'h000, 32'h1);
    chk("a_mode", 32'h10, hc.a_mode);
  endtask : t_modes
  task t_edges;
    bus(1'b1, 12'h000, 32'h4);
    for (int e = 0; e < 4; e++) begin
      bus(1'b1, 12'h00c, 32'h100 | (32'(e) << 10));
      chk("rise", (e == 0 || e == 3), hc.b_rise);
      chk("fall", (e == 1 || e == 3), hc.b_fall);
    end
  endtask : t_edges
  initial begin
    presetn = 1'b0;
    halt = 1'b0;
    pwm = 1'b0;
    trg = 1'b0;
    req = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctl();
    t_modes();
    t_edges();
    test_done();
  end
endmodule : timer_mode_control_fields_bench
`default_nettype wire
